// ==== mtp_top.sv ====
// tach pulse output and diagnostic readback registers on an APB slave
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "mtp_consts.svh"
// Behaviour
// R1: four-bit divider sets pulse rate; code 0000 gives one pulse per electrical cycle.
// R2: divider codes cover two pulses per rotation for 2 to 32 poles.
// R3: 4 poles one per cycle, 6 poles two per three, 8 poles one per two.
// R4: pulse follows commanded drive steps, not the sensed rotor.
// R5: locked rotor holds the pulse output high.
// R6: open-loop select: pulse, hold high, or pulse only on first power-on start.
// R7: speed readback in tenths of a hertz from phase-U crossing period.
// R8: period readback counts 10 us units between phase-U crossings.
// R9: back-EMF integrated per half cycle, constant refreshed each electrical cycle.
// R10: start angle stored after inductive sensing, 60 degree resolution.
// R11: start angle is sector code plus advance code, modulo 256.
// R12: supply sampled into an 8-bit code, volts = code * 30 / 256.
// R13: command from PWM duty, analog level or serial write, 8 bits of 255.
// R14: applied command readback shows the duty actually used.
// R15: fault word holds overheat, overload and six stall flags.
// R16: all readback values refresh continuously while running.
// R17: host clears fault flags by writing 0xFF to the fault word.
// R18: readback values sit at the serial target's register indices.
// R19: multi-byte readback values change as one unit.
module mtp_top (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // motor core drive state
  input  wire logic        drv_step,
  input  wire logic        zc_u,
  input  wire logic        spinning,
  input  wire logic        open_loop,
  input  wire logic        lock_active,
  // motor core fault events
  input  wire logic [5:0]  stall_evt,
  input  wire logic        overheat_evt,
  input  wire logic        overload_evt,
  // motor core measurements
  input  wire logic        emf_win,
  input  wire logic        emf_valid,
  input  wire logic [15:0] emf_sample,
  input  wire logic        ipd_done,
  input  wire logic [2:0]  ipd_sector,
  input  wire logic [1:0]  ipd_adv_sel,
  input  wire logic        supply_valid,
  input  wire logic [7:0]  supply_code,
  // speed command sources
  input  wire logic [7:0]  pwm_duty,
  input  wire logic [7:0]  analog_level,
  input  wire logic [7:0]  applied_cmd,
  // outputs
  output logic [7:0]       cmd_value,
  output logic             speed_pulse_out
);
  logic [15:0] ctrl_ff;
  logic [15:0] fault_ff;
  logic [31:0] rdata_ff;
  logic [19:0] acc_ff;
  logic [15:0] kt_ff;
  logic        win_d_ff;
  logic [7:0]  angle_ff;
  logic [7:0]  supply_ff;
  logic [7:0]  cmd_ff;
  logic [7:0]  applied_ff;
  logic        ol_d_ff;
  logic        first_done_ff;
  logic [15:0] nxt_fault;
  logic [15:0] period_w;
  logic [15:0] speed_w;

  // control fields
  wire [3:0] pulse_divider_sel  = ctrl_ff[`MTP_CTRL_DIV_LO +: 4];
  wire [1:0] openloop_pulse_sel = ctrl_ff[`MTP_CTRL_OL_LO +: 2];
  wire [1:0] cmd_src_sel        = ctrl_ff[`MTP_CTRL_SRC_LO +: 2];
  wire [7:0] serial_cmd         = ctrl_ff[`MTP_CTRL_CMD_LO +: 8];

  // apb decode; word index is the byte address over four
  wire [9:0] idx_w    = paddr[11:2];
  wire       algn_w   = (paddr[1:0] == 2'h0);
  wire       hit_flt  = algn_w && (idx_w == `MTP_IDX_FAULT); // R18
  wire       hit_spd  = algn_w && (idx_w == `MTP_IDX_SPEED); // R18
  wire       hit_per  = algn_w && (idx_w == `MTP_IDX_PERIOD);
  wire       hit_kt   = algn_w && (idx_w == `MTP_IDX_KT);
  wire       hit_ang  = algn_w && (idx_w == `MTP_IDX_ANGLE);
  wire       hit_cmd  = algn_w && (idx_w == `MTP_IDX_CMD);
  wire       hit_ctl  = algn_w && (idx_w == `MTP_IDX_CTRL);
  wire       mapped_w = hit_flt || hit_spd || hit_per || hit_kt
                        || hit_ang || hit_cmd || hit_ctl;
  wire       setup_w  = psel && !penable;
  wire       acc_w    = psel && penable;
  wire       wr_w     = acc_w && pwrite && mapped_w;
  wire       wr_ctl   = wr_w && hit_ctl;
  // the clear key must land in byte lane 0
  wire       flt_clr  = wr_w && hit_flt && pstrb[0]
                        && (pwdata[7:0] == `MTP_FLT_KEY); // R17

  // read mux, sampled in the setup phase so the data comes from flops
  wire [15:0] rd_mux =
    hit_flt ? fault_ff :
    hit_spd ? speed_w :
    hit_per ? period_w :
    hit_kt  ? kt_ff :
    hit_ang ? {angle_ff, supply_ff} :
    hit_cmd ? {cmd_ff, applied_ff} :
    hit_ctl ? ctrl_ff : 16'h0000; // R16

  // zero-wait slave; unaligned or unmapped access gets an error
  assign pready  = 1'b1;
  assign pslverr = acc_w && !mapped_w;
  assign prdata  = rdata_ff;

  // read data capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h00000000;
    end else if (setup_w && !pwrite) begin
      rdata_ff <= {16'h0000, rd_mux};
    end
  end

  // control word, byte lanes 0 and 1 honoured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `MTP_CTRL_RST;
    end else if (wr_ctl) begin
      if (pstrb[0]) begin
        ctrl_ff[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        ctrl_ff[15:8] <= pwdata[15:8];
      end
    end
  end

  // sticky faults: a new event wins over a clear in the same cycle
  wire [15:0] flt_set = {overheat_evt, 3'h0, overload_evt, 5'h00,
                         stall_evt}; // R15
  always_comb begin
    nxt_fault = fault_ff;
    if (flt_clr) begin
      nxt_fault = 16'h0000; // R17
    end
    nxt_fault = nxt_fault | flt_set; // R15
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ff <= 16'h0000;
    end else begin
      fault_ff <= nxt_fault;
    end
  end

  // back-EMF integral over the half-cycle window, stored when it closes while spinning
  wire [19:0] acc_sum = acc_ff + {4'h0, emf_sample};
  wire        win_end = win_d_ff && !emf_win;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff   <= 20'h00000;
      win_d_ff <= 1'b0;
      kt_ff    <= 16'h0000;
    end else begin
      win_d_ff <= emf_win;
      if (!emf_win) begin
        acc_ff <= 20'h00000;
      end else if (emf_valid) begin
        acc_ff <= acc_sum; // R9
      end
      // the sample scale makes the word read as 2 * 1090 per V/Hz
      if (win_end && spinning) begin
        kt_ff <= (acc_ff[19:16] != 4'h0) ? 16'hFFFF : acc_ff[15:0]; // R9 R19
      end
    end
  end

  // sector and advance code tables
  function automatic logic [7:0] sector_code(input logic [2:0] s);
    case (s)
      3'h1:    sector_code = `MTP_SEC1;
      3'h2:    sector_code = `MTP_SEC2;
      3'h3:    sector_code = `MTP_SEC3;
      3'h4:    sector_code = `MTP_SEC4;
      3'h5:    sector_code = `MTP_SEC5;
      default: sector_code = `MTP_SEC0;
    endcase
  endfunction
  function automatic logic [7:0] adv_code(input logic [1:0] a);
    case (a)
      2'h1:    adv_code = `MTP_ADV1;
      2'h2:    adv_code = `MTP_ADV2;
      2'h3:    adv_code = `MTP_ADV3;
      default: adv_code = `MTP_ADV0;
    endcase
  endfunction
  // eight-bit add wraps, which is the modulo 256 of the code
  wire [7:0] angle_w = sector_code(ipd_sector) + adv_code(ipd_adv_sel); // R11

  // command source select
  wire [7:0] cmd_w =
    (cmd_src_sel == mtp_pkg::MTP_SRC_SERIAL) ? serial_cmd :
    (cmd_src_sel == mtp_pkg::MTP_SRC_ANALOG) ? analog_level : pwm_duty; // R13

  // start angle, supply, command and applied command readbacks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      angle_ff   <= 8'h00;
      supply_ff  <= 8'h00;
      cmd_ff     <= 8'h00;
      applied_ff <= 8'h00;
    end else begin
      if (ipd_done) begin
        angle_ff <= angle_w; // R10 R11
      end
      if (supply_valid) begin
        supply_ff <= supply_code; // R12
      end
      cmd_ff     <= cmd_w; // R13 R16
      applied_ff <= applied_cmd; // R14
    end
  end
  assign cmd_value = cmd_ff;

  // first start completes when the first open-loop phase ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ol_d_ff       <= 1'b0;
      first_done_ff <= 1'b0;
    end else begin
      ol_d_ff <= open_loop;
      if (ol_d_ff && !open_loop) begin
        first_done_ff <= 1'b1; // R6
      end
    end
  end

  // hold high on lock, or in open loop as the select asks
  wire ol_hold = open_loop
    && ((openloop_pulse_sel == mtp_pkg::MTP_OL_HIGH)
    || (openloop_pulse_sel == mtp_pkg::MTP_OL_FIRST && first_done_ff)); // R6
  wire hold_w  = lock_active || ol_hold; // R5

  mtp_pulse_div u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .drv_step  (drv_step),
    .div_sel   (pulse_divider_sel),
    .hold_high (hold_w),
    .pulse_out (speed_pulse_out)
  );

  mtp_period_meas u_meas (
    .pclk       (pclk),
    .presetn    (presetn),
    .zc_u       (zc_u),
    .spinning   (spinning),
    .period_val (period_w),
    .speed_val  (speed_w)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  lock_high_a: assert property (lock_active ##1 lock_active |-> speed_pulse_out)
    else $error("pulse not high under lock"); // R5
  ol_high_a: assert property ((open_loop && openloop_pulse_sel == 2'h1)
    [*2] |-> speed_pulse_out) else $error("open-loop hold failed"); // R6
  fault_clr_a: assert property ((flt_clr && flt_set == 16'h0000)
    |=> fault_ff == 16'h0000) else $error("fault clear failed"); // R17
  fault_set_a: assert property (stall_evt[0] |=> fault_ff[0])
    else $error("stall event lost"); // R15
  angle_val_a: assert property ((ipd_done && ipd_sector == 3'h5
    && ipd_adv_sel == 2'h3) |=> angle_ff == 8'h2A) else $error("angle wrong"); // R11
  supply_cap_a: assert property (supply_valid |=> supply_ff == $past(supply_code))
    else $error("supply not captured"); // R12
  serial_cmd_a: assert property ((cmd_src_sel == 2'h2) ##1 (cmd_src_sel == 2'h2)
    |-> cmd_value == $past(serial_cmd)) else $error("serial command lost"); // R13
  kt_hold_a: assert property ($changed(kt_ff) |-> $past(win_end))
    else $error("kt changed outside window end"); // R9
  bad_addr_a: assert property ((acc_w && paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unaligned access not refused"); // R18

  clr_race_c: cover property (flt_clr && flt_set != 16'h0000);
  first_ol_c: cover property ($fell(open_loop) && !first_done_ff);
  lock_c: cover property ($rose(lock_active) ##1 speed_pulse_out);
endmodule // mtp_top

// ==== mtp_consts.svh ====
// timing counts, register indices, field positions and code tables for the tach/readback block
`ifndef MTP_CONSTS_SVH
`define MTP_CONSTS_SVH

// register indices; byte address is four times the index
`define MTP_IDX_FAULT   10'h000
`define MTP_IDX_SPEED   10'h001
`define MTP_IDX_PERIOD  10'h002
`define MTP_IDX_KT      10'h003
`define MTP_IDX_ANGLE   10'h005
`define MTP_IDX_CMD     10'h006
`define MTP_IDX_CTRL    10'h040

// control word layout and reset value
`define MTP_CTRL_RST    16'h0000
`define MTP_CTRL_DIV_LO 0
`define MTP_CTRL_OL_LO  4
`define MTP_CTRL_SRC_LO 6
`define MTP_CTRL_CMD_LO 8

// fault word layout and the clear key
`define MTP_FLT_HEAT    15
`define MTP_FLT_OVL     11
`define MTP_FLT_KEY     8'hFF

// time base: 10 us units at a 10 ns clock
`define MTP_CLK_NS      10
`define MTP_TICK_NS     10000
`define MTP_TICK_CYC    (`MTP_TICK_NS / `MTP_CLK_NS)
// tenths of a hertz times 10 us units: 10 * 100000
`define MTP_SPD_NUM     20'hF4240

// divider code for 2-pole motors and its period in drive steps
`define MTP_DIV_2POLE   4'hF
`define MTP_PER_2POLE   6'h03

// sector codes for 0..300 degrees, advance codes for 30..120 degrees
`define MTP_SEC0        8'h00
`define MTP_SEC1        8'h2B
`define MTP_SEC2        8'h55
`define MTP_SEC3        8'h80
`define MTP_SEC4        8'hAB
`define MTP_SEC5        8'hD5
`define MTP_ADV0        8'h16
`define MTP_ADV1        8'h2C
`define MTP_ADV2        8'h3F
`define MTP_ADV3        8'h55

`endif

// ==== mtp_pkg.sv ====
// types shared by the tach/readback block
package mtp_pkg;
  // open-loop pulse behaviour
  typedef enum logic [1:0] {
    MTP_OL_PULSE = 2'h0,
    MTP_OL_HIGH  = 2'h1,
    MTP_OL_FIRST = 2'h2
  } mtp_ol_e;
  // speed command source
  typedef enum logic [1:0] {
    MTP_SRC_PWM    = 2'h0,
    MTP_SRC_ANALOG = 2'h1,
    MTP_SRC_SERIAL = 2'h2
  } mtp_src_e;
  // divider state machine
  typedef enum logic [2:0] {
    MTP_ST_IDLE = 3'h1,
    MTP_ST_DIV  = 3'h2,
    MTP_ST_LOAD = 3'h4
  } mtp_div_st_e;
endpackage

// ==== mtp_pulse_div.sv ====
// tach pulse divider driven by commanded drive steps
`timescale 1ns/1ps
`include "mtp_consts.svh"
module mtp_pulse_div (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // drive side
  input  wire logic       drv_step,
  input  wire logic [3:0] div_sel,
  input  wire logic       hold_high,
  // pin
  output logic            pulse_out
);
  logic [5:0] cnt_ff;
  logic       out_ff;
  wire  [5:0] per_w;
  wire  [5:0] nxt_cnt;

  // period in drive steps: 1.5 steps per pole, 4 poles at code 0
  function automatic logic [5:0] steps_of(input logic [3:0] sel);
    if (sel == `MTP_DIV_2POLE) begin
      steps_of = `MTP_PER_2POLE;
    end else begin
      steps_of = ({2'h0, sel} + 6'h02) * 6'h03;
    end
  endfunction

  assign per_w   = steps_of(div_sel); // R1 R2 R3
  // a counter past a shrunken period restarts instead of running away
  assign nxt_cnt = (cnt_ff >= per_w - 6'h01) ? 6'h00 : cnt_ff + 6'h01;

  // count steps; held output restarts the pattern cleanly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 6'h00;
      out_ff <= 1'b1;
    end else begin
      if (hold_high) begin
        cnt_ff <= 6'h00;
      end else if (drv_step) begin
        cnt_ff <= nxt_cnt; // R4
      end
      out_ff <= hold_high | (cnt_ff < (per_w >> 1)); // R1 R5
    end
  end
  assign pulse_out = out_ff;

  held_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_high |=> pulse_out) else $error("held pulse not high"); // R5
  default_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    (div_sel == 4'h0 && !hold_high && cnt_ff == 6'h05 && drv_step)
    |=> cnt_ff == 6'h00) else $error("default period not six steps"); // R1
  pulse_run_c: cover property (@(posedge pclk) disable iff (!presetn)
    !hold_high && $fell(pulse_out));
endmodule // mtp_pulse_div

// ==== mtp_period_meas.sv ====
// electrical period timer and speed divider on phase-U zero crossings
`timescale 1ns/1ps
`include "mtp_consts.svh"
module mtp_period_meas (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // core
  input  wire logic        zc_u,
  input  wire logic        spinning,
  // readback
  output logic [15:0]      period_val,
  output logic [15:0]      speed_val
);
  mtp_pkg::mtp_div_st_e st_ff;
  logic [9:0]  tick_ff;
  logic [15:0] cnt_ff;
  logic [15:0] dsr_ff;
  logic [16:0] rem_ff;
  logic [19:0] quo_ff;
  logic [4:0]  itr_ff;
  logic [15:0] per_ff;
  logic [15:0] spd_ff;
  wire         tick_w;
  wire         take_w;
  wire  [16:0] sh_w;
  wire         ge_w;
  wire  [15:0] meas_w;

  assign tick_w = (tick_ff == 10'(`MTP_TICK_CYC - 1));
  // zero crossings during a division are skipped; it lasts 21 cycles
  assign take_w = zc_u && spinning && (st_ff == mtp_pkg::MTP_ST_IDLE);
  assign sh_w   = {rem_ff[15:0], quo_ff[19]};
  assign ge_w   = (sh_w >= {1'b0, dsr_ff});
  // a tick that completes on the crossing edge still belongs to this period
  assign meas_w = (tick_w && cnt_ff != 16'hFFFF) ? cnt_ff + 16'h0001 : cnt_ff;

  // 10 us tick and saturating period counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= 10'h000;
      cnt_ff  <= 16'h0000;
    end else begin
      tick_ff <= (tick_w || take_w) ? 10'h000 : tick_ff + 10'h001;
      if (take_w) begin
        cnt_ff <= 16'h0000;
      end else if (tick_w && cnt_ff != 16'hFFFF) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  // restoring division of the speed numerator by the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff  <= mtp_pkg::MTP_ST_IDLE;
      dsr_ff <= 16'h0000;
      rem_ff <= 17'h00000;
      quo_ff <= 20'h00000;
      itr_ff <= 5'h00;
      per_ff <= 16'h0000;
      spd_ff <= 16'h0000;
    end else begin
      case (st_ff)
        mtp_pkg::MTP_ST_IDLE: begin
          if (take_w && meas_w != 16'h0000) begin
            dsr_ff <= meas_w; // R8
            rem_ff <= 17'h00000;
            quo_ff <= `MTP_SPD_NUM;
            itr_ff <= 5'h00;
            st_ff  <= mtp_pkg::MTP_ST_DIV;
          end
        end
        mtp_pkg::MTP_ST_DIV: begin
          rem_ff <= ge_w ? sh_w - {1'b0, dsr_ff} : sh_w;
          quo_ff <= {quo_ff[18:0], ge_w};
          itr_ff <= itr_ff + 5'h01;
          if (itr_ff == 5'h13) begin
            st_ff <= mtp_pkg::MTP_ST_LOAD;
          end
        end
        mtp_pkg::MTP_ST_LOAD: begin
          // both values change on the same edge so a reader never mixes them
          per_ff <= dsr_ff; // R8 R19
          spd_ff <= (quo_ff[19:16] != 4'h0) ? 16'hFFFF : quo_ff[15:0]; // R7 R19
          st_ff  <= mtp_pkg::MTP_ST_IDLE;
        end
        default: st_ff <= mtp_pkg::MTP_ST_IDLE;
      endcase
    end
  end
  assign period_val = per_ff;
  assign speed_val  = spd_ff;

  pair_update_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(per_ff) |-> $past(st_ff) == mtp_pkg::MTP_ST_LOAD)
    else $error("period changed outside load"); // R19
  div_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff == mtp_pkg::MTP_ST_IDLE && take_w && meas_w != 16'h0000)
    |-> ##21 st_ff == mtp_pkg::MTP_ST_LOAD) else $error("division length wrong"); // R7
  speed_upd_c: cover property (@(posedge pclk) disable iff (!presetn)
    st_ff == mtp_pkg::MTP_ST_LOAD);
endmodule // mtp_period_meas

// ==== mtp_host_model.sv ====
// host-side tach watcher: counts drive steps between rising edges of the tach pin
`timescale 1ns/1ps
module mtp_host_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // observed lines
  input  wire logic       speed_pulse_out,
  input  wire logic       drv_step,
  // measurements
  output logic [7:0]      per_steps,
  output logic [7:0]      rise_cnt
);
  logic       prev_ff;
  logic [7:0] step_ff;
  // a rising edge closes a tach period; a held pin never closes one, so no period is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff   <= 1'b1;
      step_ff   <= 8'h00;
      per_steps <= 8'h00;
      rise_cnt  <= 8'h00;
    end else begin
      prev_ff <= speed_pulse_out;
      if (speed_pulse_out && !prev_ff) begin
        per_steps <= step_ff;
        rise_cnt  <= rise_cnt + 8'h01;
        step_ff   <= {7'h00, drv_step};
      end else begin
        step_ff <= step_ff + {7'h00, drv_step};
      end
    end
  end
endmodule // mtp_host_model

// ==== mtp_top_tb_top.sv ====
// self-checking bench for the tach pulse and readback block
`timescale 1ns/1ps
`include "mtp_consts.svh"
module mtp_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, moved;
  logic        drv_step, zc_u, spinning, open_loop, lock_active, overheat_evt, overload_evt;
  logic        emf_win, emf_valid, ipd_done, supply_valid, speed_pulse_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [5:0]  stall_evt;
  logic [15:0] emf_sample;
  logic [2:0]  ipd_sector;
  logic [1:0]  ipd_adv_sel;
  logic [7:0]  supply_code, pwm_duty, analog_level, applied_cmd, cmd_value;
  logic [7:0]  per_steps, rise_cnt, r0;
  int          miscompares, cmp_count, cyc;
  logic [7:0]  sec_t [6] = '{8'h00, 8'h2B, 8'h55, 8'h80, 8'hAB, 8'hD5};
  logic [7:0]  adv_t [4] = '{8'h16, 8'h2C, 8'h3F, 8'h55};
  logic [3:0]  dc_t [5] = '{4'h0, 4'h1, 4'h2, 4'hE, 4'hF};
  int          pl_t [5] = '{4, 6, 8, 32, 2};
  logic [7:0]  cx_t [4] = '{8'h11, 8'h22, 8'h33, 8'h11};

  mtp_top mtp_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .drv_step, .zc_u, .spinning, .open_loop, .lock_active,
    .stall_evt, .overheat_evt, .overload_evt, .emf_win, .emf_valid, .emf_sample, .ipd_done,
    .ipd_sector, .ipd_adv_sel, .supply_valid, .supply_code, .pwm_duty, .analog_level,
    .applied_cmd, .cmd_value, .speed_pulse_out);
  mtp_host_model mtp_host_model_inst (.pclk, .presetn, .speed_pulse_out, .drv_step,
    .per_steps, .rise_cnt);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // a hung wait still ends in the closing report
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: timeout", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge or 100 edges pass
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 100);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(q, x, "read data");
    chk({31'h0, e}, {31'h0, xe}, "read error");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // drive steps four cycles apart, as the core would issue them
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge pclk) drv_step <= 1'b1;
      @(posedge pclk) drv_step <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  task automatic zc();
    @(posedge pclk) zc_u <= 1'b1;
    @(posedge pclk) zc_u <= 1'b0;
  endtask

  // runs steps in open loop and reports whether the pin produced edges
  task automatic olchk(input logic [1:0] sel, input logic moves);
    wr(12'h100, {26'h0, sel, 4'h0});
    open_loop <= 1'b1;
    @(posedge pclk);
    r0 = rise_cnt;
    steps(12);
    moved = (rise_cnt != r0);
    chk({31'h0, moved}, {31'h0, moves}, "open loop edges");
    if (!moves) chk({31'h0, speed_pulse_out}, 32'h1, "open loop hold");
    @(posedge pclk) open_loop <= 1'b0;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, drv_step, zc_u, spinning} = '0;
    {open_loop, lock_active, stall_evt, overheat_evt, overload_evt, emf_win} = '0;
    {emf_valid, emf_sample, ipd_done, ipd_sector, ipd_adv_sel, supply_valid} = '0;
    supply_code = 8'h00;
    pstrb = 4'hF;
    pwm_duty = 8'h11;
    analog_level = 8'h22;
    applied_cmd = 8'h44;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h100, 32'h0, 1'b0);
    rd(12'h000, 32'h0, 1'b0);
    chk({31'h0, speed_pulse_out}, 32'h1, "pin at reset");
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(12'h100, {28'h0, dc_t[i]});
      steps(9 * pl_t[i] / 2);
      chk({24'h0, per_steps}, 32'(3 * pl_t[i] / 2), "tach period");
    end
    $display("test divider done");
    // option2 must come first: only the first open-loop start since reset pulses
    olchk(2'h2, 1'b1);
    olchk(2'h2, 1'b0);
    olchk(2'h1, 1'b0);
    olchk(2'h0, 1'b1);
    olchk(2'h3, 1'b1);
    $display("test open loop done");
    lock_active <= 1'b1;
    @(posedge pclk);
    r0 = rise_cnt;
    steps(15);
    chk({24'h0, rise_cnt}, {24'h0, r0}, "lock edges");
    chk({31'h0, speed_pulse_out}, 32'h1, "lock level");
    lock_active <= 1'b0;
    $display("test lock done");
    spinning <= 1'b1;
    zc();
    repeat (19998) @(posedge pclk);
    zc();
    repeat (30) @(posedge pclk);
    rd(12'h008, 32'(20000 * `MTP_CLK_NS / `MTP_TICK_NS), 1'b0);
    rd(12'h004, 32'(`MTP_SPD_NUM / 20), 1'b0);
    spinning <= 1'b0;
    repeat (5000) @(posedge pclk);
    zc();
    repeat (30) @(posedge pclk);
    wr(12'h004, 32'hFFFF);
    rd(12'h008, 32'h14, 1'b0);
    rd(12'h004, 32'hC350, 1'b0);
    $display("test measurement done");
    spinning <= 1'b1;
    @(posedge pclk) {emf_valid, emf_sample} <= {1'b1, 16'h0007};
    @(posedge pclk) {emf_win, emf_sample} <= {1'b1, 16'h0100};
    @(posedge pclk) emf_sample <= 16'h0200;
    @(posedge pclk) {emf_valid, emf_sample} <= {1'b0, 16'h0400};
    @(posedge pclk) emf_win <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(12'h00C, 32'h0300, 1'b0);
    $display("test emf done");
    @(posedge pclk) {supply_valid, supply_code} <= {1'b1, 8'h5A};
    @(posedge pclk) supply_valid <= 1'b0;
    for (int s = 0; s < 6; s++) begin
      for (int a = 0; a < 4; a++) begin
        @(posedge pclk) {ipd_done, ipd_sector, ipd_adv_sel} <= {1'b1, 3'(s), 2'(a)};
        @(posedge pclk) ipd_done <= 1'b0;
        rd(12'h014, {16'h0, 8'(sec_t[s] + adv_t[a]), 8'h5A}, 1'b0);
      end
    end
    $display("test angle done");
    for (int c = 0; c < 4; c++) begin
      wr(12'h100, {16'h0, 8'h33, 2'(c), 6'h0});
      repeat (2) @(posedge pclk);
      chk({24'h0, cmd_value}, {24'h0, cx_t[c]}, "command pin");
      rd(12'h018, {16'h0, cx_t[c], 8'h44}, 1'b0);
    end
    $display("test command done");
    @(posedge pclk) {overheat_evt, overload_evt, stall_evt} <= {2'h3, 6'h2A};
    @(posedge pclk) {overheat_evt, overload_evt, stall_evt} <= {2'h0, 6'h15};
    @(posedge pclk) stall_evt <= 6'h00;
    rd(12'h000, 32'h883F, 1'b0);
    wr(12'h000, 32'h00FE);
    rd(12'h000, 32'h883F, 1'b0);
    wr(12'h000, 32'h00FF);
    rd(12'h000, 32'h0, 1'b0);
    $display("test fault done");
    rd(12'h010, 32'h0, 1'b1);
    rd(12'h006, 32'h0, 1'b1);
    rd(12'h200, 32'h0, 1'b1);
    $display("test address done");
    give_verdict();
  end
endmodule // mtp_top_tb_top
